// ===== verilog/dpm_pkg.sv
// Shared constants, carriers and state types for the per-port MII logic.
package dpm_pkg;

  localparam int CLK_HZ       = 20_000_000;
  localparam int CLK_10_HZ    = 2_500_000;
  localparam int CLK_100_HZ   = 25_000_000;
  localparam int HALF_10_INT  = (CLK_HZ / (2 * CLK_10_HZ)) < 1 ? 1 : CLK_HZ / (2 * CLK_10_HZ);
  localparam int HALF_100_INT = (CLK_HZ / (2 * CLK_100_HZ)) < 1 ? 1 : CLK_HZ / (2 * CLK_100_HZ);
  localparam int DIV_W        = 4;
  localparam logic [DIV_W-1:0] HALF_10_CYC  = DIV_W'(HALF_10_INT);
  localparam logic [DIV_W-1:0] HALF_100_CYC = DIV_W'(HALF_100_INT);

  localparam logic [1:0] INIT_CYC      = 2'h3;
  localparam logic [5:0] PREAMBLE_LEN  = 6'h20;
  localparam logic [4:0] HDR_LAST      = 5'h0C;
  localparam logic [4:0] DATA_LAST     = 5'h0F;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [4:0] CTRL_REG_ADDR = 5'h00;
  localparam int CTRL_RESET_BIT  = 15;
  localparam int CTRL_SPEED_BIT  = 13;
  localparam int CTRL_DUPLEX_BIT = 8;

  localparam int FIFO_DEPTH = 16;
  localparam int RX_WORD_W  = 5;

  typedef struct packed {
    logic       en;
    logic       er;
    logic [3:0] data;
  } dpm_tx_s;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] data;
  } dpm_rx_s;

  typedef struct packed {
    logic speed_100;
    logic full_duplex;
  } dpm_cfg_s;

  typedef struct packed {
    dpm_tx_s    mac_tx;
    logic       mdc;
    logic       mdio;
    logic       strap;
    logic [3:0] addr_high;
    logic       speed;
    logic       duplex;
    logic       line_clk;
    dpm_rx_s    line_rx;
  } dpm_pins_s;

  typedef enum logic [1:0] {MD_PRE, MD_HDR, MD_TA, MD_DATA} dpm_mdio_e;

endpackage : dpm_pkg

// ===== verilog/dpm_port.sv
// One MII port of the dual PHY: clocks, nibble paths, carrier/collision and management slave.
`timescale 1ns/1ns
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module dpm_fifo
#(
  parameter int WIDTH = 5,
  parameter int DEPTH = 16
)
(
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire logic             flush_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  // Full and empty are kept as registers so both handshakes leave straight from flops.
  always_comb
  begin
    push        = in_valid_i && in_ready_o;
    pop         = out_valid_o && out_ready_i;
    next_wr_ptr = wr_ptr + AW'(push);
    next_rd_ptr = rd_ptr + AW'(pop);
    next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_i)
    begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_count  = '0;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      count       <= '0;
      in_ready_o  <= 1'h0;
      out_valid_o <= 1'h0;
    end
    else
    begin
      wr_ptr      <= next_wr_ptr;
      rd_ptr      <= next_rd_ptr;
      count       <= next_count;
      in_ready_o  <= next_count != (AW+1)'(DEPTH);
      out_valid_o <= next_count != '0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (push && !flush_i)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  assign out_data_o = mem[rd_ptr];

endmodule : dpm_fifo

////////////////////////////////////////////////////////////////////////////////
module dpm_port
#(
  parameter int PORT_INDEX = 0,
  parameter int RX_DEPTH   = dpm_pkg::FIFO_DEPTH
)
(
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  input  wire dpm_pkg::dpm_tx_s mii_tx_i,
  output logic                  mii_txclk_o,
  output logic                  mii_rxclk_o,
  output dpm_pkg::dpm_rx_s      mii_rx_o,
  output logic                  mii_crs_o,
  output logic                  mii_col_o,
  input  wire logic             mdc_i,
  input  wire logic             mdio_i,
  output logic                  mdio_o,
  output logic                  mdio_oe_n_o,
  input  wire logic             management_disable_strap_i,
  input  wire logic [3:0]       phy_address_strap_high_i,
  input  wire logic             speed_pin_i,
  input  wire logic             duplex_pin_i,
  input  wire logic             line_rx_clk_i,
  input  wire dpm_pkg::dpm_rx_s line_rx_i,
  output logic                  line_rx_ready_o,
  output dpm_pkg::dpm_tx_s      line_tx_o,
  output logic [4:0]            phy_address_o,
  output dpm_pkg::dpm_cfg_s     cfg_o
);
  import dpm_pkg::*;

  dpm_pins_s        pins_a;
  dpm_pins_s        pins_s;
  logic             mdc_prev;
  logic             line_clk_prev;
  logic             mdc_rise;
  logic             line_rise;
  logic             normal;

  logic [1:0]       init_cnt;
  logic             mgmt_off;
  dpm_mdio_e        md_state;
  logic [5:0]       md_ones;
  logic [4:0]       md_cnt;
  logic [12:0]      md_hdr;
  logic [15:0]      md_shift;
  logic [1:0]       next_init_cnt;
  dpm_cfg_s         next_cfg;
  logic             next_mgmt_off;
  logic [4:0]       next_phy_addr;
  dpm_mdio_e        next_md_state;
  logic [5:0]       next_md_ones;
  logic [4:0]       next_md_cnt;
  logic [12:0]      next_md_hdr;
  logic [15:0]      next_md_shift;
  logic             next_mdio_o;
  logic             next_mdio_oe_n;
  logic [12:0]      hdr_word;
  logic [15:0]      wr_word;
  logic [15:0]      rd_word;
  logic             soft_req;

  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic [DIV_W-1:0] half;
  logic             next_link_clk;
  logic             rise_evt;
  logic             fall_evt;
  dpm_tx_s          next_line_tx;
  dpm_rx_s          next_mii_rx;
  logic             next_crs;
  logic             next_col;
  logic             rx_busy;
  logic             fifo_out_valid;
  logic             fifo_ready;
  logic [RX_WORD_W-1:0] fifo_out_data;

  ////////////////////////////////////////////////////////////////////////////////
  // Every pin passes two flops; edges of the management and line clocks are found here.
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      pins_a        <= '0;
      pins_s        <= '0;
      mdc_prev      <= 1'h0;
      line_clk_prev <= 1'h0;
    end
    else
    begin
      pins_a        <= {mii_tx_i, mdc_i, mdio_i, management_disable_strap_i, phy_address_strap_high_i,
                        speed_pin_i, duplex_pin_i, line_rx_clk_i, line_rx_i};
      pins_s        <= pins_a;
      mdc_prev      <= pins_s.mdc;
      line_clk_prev <= pins_s.line_clk;
    end
  end

  assign mdc_rise  = pins_s.mdc && !mdc_prev;
  assign line_rise = pins_s.line_clk && !line_clk_prev;
  assign normal    = init_cnt == 2'h0;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset sequencing, strap capture and the management serial slave.
  always_comb
  begin
    next_init_cnt  = init_cnt;
    next_cfg       = cfg_o;
    next_mgmt_off  = mgmt_off;
    next_phy_addr  = phy_address_o;
    next_md_state  = md_state;
    next_md_ones   = md_ones;
    next_md_cnt    = md_cnt;
    next_md_hdr    = md_hdr;
    next_md_shift  = md_shift;
    next_mdio_o    = mdio_o;
    next_mdio_oe_n = mdio_oe_n_o;
    soft_req       = 1'h0;
    hdr_word       = {md_hdr[11:0], pins_s.mdio};
    wr_word        = {md_shift[14:0], pins_s.mdio};
    rd_word        = '0;
    rd_word[CTRL_SPEED_BIT]  = cfg_o.speed_100;
    rd_word[CTRL_DUPLEX_BIT] = cfg_o.full_duplex;
    if (init_cnt != 2'h0)
    begin
      // Straps are caught on the last init cycle, once the synchronisers hold real pin levels.
      next_init_cnt  = init_cnt - 2'h1;
      next_md_state  = MD_PRE;
      next_md_ones   = '0;
      next_mdio_oe_n = 1'h1;
      if (init_cnt == 2'h1)
      begin
        next_cfg.speed_100   = pins_s.speed;
        next_cfg.full_duplex = pins_s.duplex;
        next_mgmt_off        = pins_s.strap;
        next_phy_addr        = {pins_s.addr_high, 1'(PORT_INDEX)};
      end
    end
    else if (mgmt_off)
    begin
      next_mdio_oe_n = 1'h1;
      next_md_state  = MD_PRE;
    end
    else if (mdc_rise)
    begin
      case (md_state)
        MD_PRE:
        begin
          if (pins_s.mdio)
          begin
            next_md_ones = (md_ones == PREAMBLE_LEN) ? md_ones : md_ones + 6'h01;
          end
          else if (md_ones == PREAMBLE_LEN)
          begin
            next_md_state = MD_HDR;
            next_md_cnt   = '0;
          end
          else
          begin
            next_md_ones = '0;
          end
        end
        MD_HDR:
        begin
          next_md_hdr = hdr_word;
          next_md_cnt = md_cnt + 5'h01;
          if (md_cnt == HDR_LAST)
          begin
            next_md_ones  = '0;
            next_md_cnt   = '0;
            next_md_state = MD_TA;
            next_md_shift = (hdr_word[4:0] == CTRL_REG_ADDR) ? rd_word : 16'h0000;
            if (!hdr_word[12] || hdr_word[9:5] != phy_address_o ||
                (hdr_word[11:10] != OP_READ && hdr_word[11:10] != OP_WRITE))
            begin
              next_md_state = MD_PRE;
            end
          end
        end
        MD_TA:
        begin
          if (md_cnt == 5'h00)
          begin
            next_md_cnt = 5'h01;
            if (md_hdr[11:10] == OP_READ)
            begin
              // The station has let go during the first turnaround bit; claim the line now.
              next_mdio_o    = 1'h0;
              next_mdio_oe_n = 1'h0;
            end
          end
          else
          begin
            next_md_state = MD_DATA;
            next_md_cnt   = '0;
            if (md_hdr[11:10] == OP_READ)
            begin
              next_mdio_o   = md_shift[15];
              next_md_shift = {md_shift[14:0], 1'h0};
            end
          end
        end
        MD_DATA:
        begin
          next_md_cnt = md_cnt + 5'h01;
          if (md_hdr[11:10] == OP_WRITE)
          begin
            next_md_shift = wr_word;
            if (md_cnt == DATA_LAST)
            begin
              next_md_state = MD_PRE;
              if (md_hdr[4:0] == CTRL_REG_ADDR)
              begin
                next_cfg.speed_100   = wr_word[CTRL_SPEED_BIT];
                next_cfg.full_duplex = wr_word[CTRL_DUPLEX_BIT];
                if (wr_word[CTRL_RESET_BIT])
                begin
                  soft_req      = 1'h1;
                  next_init_cnt = INIT_CYC;
                end
              end
            end
          end
          else if (md_cnt == DATA_LAST)
          begin
            next_mdio_oe_n = 1'h1;
            next_md_state  = MD_PRE;
          end
          else
          begin
            next_mdio_o   = md_shift[15];
            next_md_shift = {md_shift[14:0], 1'h0};
          end
        end
        default:
        begin
          next_md_state = MD_PRE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      init_cnt      <= INIT_CYC;
      cfg_o         <= '0;
      mgmt_off      <= 1'h1;
      phy_address_o <= '0;
      md_state      <= MD_PRE;
      md_ones       <= '0;
      md_cnt        <= '0;
      md_hdr        <= '0;
      md_shift      <= '0;
      mdio_o        <= 1'h0;
      mdio_oe_n_o   <= 1'h1;
    end
    else
    begin
      init_cnt      <= next_init_cnt;
      cfg_o         <= next_cfg;
      mgmt_off      <= next_mgmt_off;
      phy_address_o <= next_phy_addr;
      md_state      <= next_md_state;
      md_ones       <= next_md_ones;
      md_cnt        <= next_md_cnt;
      md_hdr        <= next_md_hdr;
      md_shift      <= next_md_shift;
      mdio_o        <= next_mdio_o;
      mdio_oe_n_o   <= next_mdio_oe_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive buffer between the line clock and the generated receive clock.
  dpm_fifo #(
    .WIDTH (RX_WORD_W),
    .DEPTH (RX_DEPTH)
  ) u_rx_fifo (
    .clk_i       (clk_i),
    .reset_n_i   (reset_n_i),
    .flush_i     (!normal),
    .in_valid_i  (line_rise && pins_s.line_rx.dv && normal),
    .in_ready_o  (fifo_ready),
    .in_data_i   ({pins_s.line_rx.er, pins_s.line_rx.data}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (fall_evt),
    .out_data_o  (fifo_out_data)
  );

  assign line_rx_ready_o = fifo_ready;

  ////////////////////////////////////////////////////////////////////////////////
  // MII clocks, transmit sampling, receive launch, carrier and collision.
  // A 20 MHz clock cannot make 25 MHz; the fast rate runs at the quickest toggle available.
  always_comb
  begin
    half          = cfg_o.speed_100 ? HALF_100_CYC : HALF_10_CYC;
    next_div_cnt  = div_cnt + 4'h1;
    next_link_clk = mii_txclk_o;
    rise_evt      = 1'h0;
    fall_evt      = 1'h0;
    if (div_cnt >= half - 4'h1)
    begin
      next_div_cnt  = '0;
      next_link_clk = !mii_txclk_o;
      rise_evt      = !mii_txclk_o;
      fall_evt      = mii_txclk_o;
    end
    next_line_tx = line_tx_o;
    if (!normal)
    begin
      next_line_tx = '0;
    end
    else if (rise_evt)
    begin
      next_line_tx.en   = pins_s.mac_tx.en;
      next_line_tx.data = pins_s.mac_tx.data;
      next_line_tx.er   = pins_s.mac_tx.en && pins_s.mac_tx.er && cfg_o.speed_100;
    end
    next_mii_rx = mii_rx_o;
    if (!normal)
    begin
      next_mii_rx = '0;
    end
    else if (fall_evt)
    begin
      next_mii_rx.dv   = fifo_out_valid;
      next_mii_rx.er   = fifo_out_valid && fifo_out_data[4];
      next_mii_rx.data = fifo_out_valid ? fifo_out_data[3:0] : 4'h0;
    end
    rx_busy  = pins_s.line_rx.dv || mii_rx_o.dv;
    next_crs = normal && (rx_busy || (!cfg_o.full_duplex && pins_s.mac_tx.en));
    next_col = normal && !cfg_o.full_duplex && pins_s.mac_tx.en && pins_s.line_rx.dv;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      div_cnt     <= '0;
      mii_txclk_o <= 1'h0;
      mii_rxclk_o <= 1'h0;
      line_tx_o   <= '0;
      mii_rx_o    <= '0;
      mii_crs_o   <= 1'h0;
      mii_col_o   <= 1'h0;
    end
    else
    begin
      div_cnt     <= next_div_cnt;
      mii_txclk_o <= next_link_clk;
      mii_rxclk_o <= next_link_clk;
      line_tx_o   <= next_line_tx;
      mii_rx_o    <= next_mii_rx;
      mii_crs_o   <= next_crs;
      mii_col_o   <= next_col;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Clock phases are only judged while the slow rate holds through the whole phase.
  // A speed change in mid-phase legally shortens that one phase.
  sequence s_slow_run;
    (!cfg_o.speed_100) [*4];
  endsequence

  sequence s_init_run;
    !normal [*3] ##1 normal;
  endsequence

  property p_tx_ignored;
    !normal |=> line_tx_o == '0;
  endproperty
  a_tx_ignored: assert property (p_tx_ignored) else $error("line transmit active outside normal mode");

  property p_tx_h_symbols;
    rise_evt && normal && pins_s.mac_tx.en && pins_s.mac_tx.er && cfg_o.speed_100 |=> line_tx_o.er;
  endproperty
  a_tx_h_symbols: assert property (p_tx_h_symbols) else $error("transmit error did not force H symbols");

  property p_tx_no_h_at_10;
    rise_evt && !cfg_o.speed_100 |=> !line_tx_o.er;
  endproperty
  a_tx_no_h_at_10: assert property (p_tx_no_h_at_10) else $error("H symbols sent at 10 Mbps");

  property p_txclk_10;
    $rose(mii_txclk_o) ##0 s_slow_run |->
      mii_txclk_o && $past(mii_txclk_o) && $past(mii_txclk_o, 2) ##1 !mii_txclk_o;
  endproperty
  a_txclk_10: assert property (p_txclk_10) else $error("transmit clock high phase wrong at 10 Mbps");

  property p_rxclk_10;
    $fell(mii_rxclk_o) ##0 s_slow_run |->
      !mii_rxclk_o && !$past(mii_rxclk_o) && !$past(mii_rxclk_o, 2) ##1 mii_rxclk_o;
  endproperty
  a_rxclk_10: assert property (p_rxclk_10) else $error("receive clock low phase wrong at 10 Mbps");

  property p_rx_stable;
    !fall_evt && normal && next_init_cnt == 2'h0 |=> $stable(mii_rx_o);
  endproperty
  a_rx_stable: assert property (p_rx_stable) else $error("receive nibble moved between clock edges");

  property p_rx_valid;
    fall_evt && normal && fifo_out_valid |=> mii_rx_o.dv && mii_rx_o.data == $past(fifo_out_data[3:0]);
  endproperty
  a_rx_valid: assert property (p_rx_valid) else $error("buffered nibble not presented as valid");

  property p_rx_idle;
    fall_evt && !fifo_out_valid |=> !mii_rx_o.dv;
  endproperty
  a_rx_idle: assert property (p_rx_idle) else $error("data valid raised with an empty buffer");

  property p_rx_error;
    fall_evt && normal && fifo_out_valid && fifo_out_data[4] |=> mii_rx_o.er;
  endproperty
  a_rx_error: assert property (p_rx_error) else $error("bad symbol not flagged as receive error");

  property p_col_full;
    cfg_o.full_duplex |=> !mii_col_o;
  endproperty
  a_col_full: assert property (p_col_full) else $error("collision raised in full duplex");

  property p_crs_half;
    normal && !cfg_o.full_duplex && pins_s.mac_tx.en |=> mii_crs_o;
  endproperty
  a_crs_half: assert property (p_crs_half) else $error("carrier sense missed transmit in half duplex");

  property p_crs_full;
    cfg_o.full_duplex && !pins_s.line_rx.dv && !mii_rx_o.dv |=> !mii_crs_o;
  endproperty
  a_crs_full: assert property (p_crs_full) else $error("carrier sense without receive in full duplex");

  property p_mgmt_off;
    mgmt_off |=> mdio_oe_n_o;
  endproperty
  a_mgmt_off: assert property (p_mgmt_off) else $error("management pin driven while disabled");

  property p_strap_load;
    init_cnt == 2'h1 |=> cfg_o.speed_100 == $past(pins_s.speed) && mgmt_off == $past(pins_s.strap);
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("pins not loaded at end of reset");

  property p_soft_reset;
    soft_req |=> s_init_run;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not rerun initialisation");

  property p_port_bit;
    normal |-> phy_address_o[0] == 1'(PORT_INDEX);
  endproperty
  a_port_bit: assert property (p_port_bit) else $error("address low bit differs from port index");

endmodule : dpm_port

`default_nettype wire

// ===== testbench/dpm_sta_model.sv
// Management station model that clocks serial frames onto one port's shared data wire.
`timescale 1ns/1ns
`default_nettype none
module dpm_sta_model
(
  input  wire logic phy_data_i,
  input  wire logic phy_oe_n_i,
  output logic      mdc_o,
  output logic      mdio_o
);
  logic drv;
  logic en;
  // The wire has a pull-up, so a released line reads high instead of its last value.
  assign mdio_o = !phy_oe_n_i ? phy_data_i : (en ? drv : 1'h1);
  initial
  begin
    mdc_o = 1'h0;
    drv = 1'h1;
    en = 1'h0;
  end
  // Half periods of 200 ns keep every bit well over three system clocks long.
  task automatic xfer(input logic [31:0] f, output logic [15:0] rd);
    rd = 16'h0000;
    for (int i = 0; i < 64; i++)
    begin
      #200 mdc_o = 1'h0;
      drv = (i < 32) ? 1'h1 : f[63 - i];
      en = !(f[29:28] == 2'h2 && i >= 46);
      #200 mdc_o = 1'h1;
      if (i >= 48)
        rd = {rd[14:0], mdio_o};
    end
    #200 mdc_o = 1'h0;
    en = 1'h0;
  endtask : xfer
endmodule : dpm_sta_model
`default_nettype wire

// ===== testbench/dpm_port_bench.sv
// Bench for both MII ports, each with its own management station model.
`timescale 1ns/1ns
`default_nettype none
module dpm_port_bench;
  import dpm_pkg::*;
  typedef struct packed {dpm_tx_s tx; dpm_rx_s lrx; dpm_tx_s ltx; dpm_rx_s rx; logic chk; logic crs; logic col;} dpm_row_s;
  // Rows 0 to 3 run at 10 Mbps in half duplex, rows 4 and 5 at the fast rate in full duplex.
  localparam dpm_row_s ROWS [6] = '{
    '{6'h2A, 6'h00, 6'h2A, 6'h00, 1'h1, 1'h1, 1'h0},
    '{6'h35, 6'h2C, 6'h25, 6'h2C, 1'h1, 1'h1, 1'h1},
    '{6'h00, 6'h33, 6'h00, 6'h33, 1'h1, 1'h1, 1'h0},
    '{6'h00, 6'h00, 6'h00, 6'h00, 1'h1, 1'h0, 1'h0},
    '{6'h36, 6'h00, 6'h36, 6'h00, 1'h1, 1'h0, 1'h0},
    '{6'h22, 6'h27, 6'h22, 6'h00, 1'h0, 1'h1, 1'h0}};
  logic        clk, reset_n, lclk;
  dpm_tx_s     tx;
  dpm_rx_s     lrx;
  logic [15:0] rd;
  int          error_cnt, check_count;
  wire logic   mdc [2], mdw [2], mdo [2], oen [2], txc [2], rxc [2], crs [2], col [2], rdy [2];
  wire dpm_rx_s  rx [2];
  wire dpm_tx_s  ltx [2];
  wire dpm_cfg_s cfg [2];
  wire logic [4:0] pa [2];
////////////////////////////////////////////////////////////////////////////////
  for (genvar p = 0; p < 2; p++)
  begin : g
    dpm_port #(.PORT_INDEX(p)) dpm_port_i
    (
      .clk_i(clk), .reset_n_i(reset_n), .mii_tx_i(tx), .mii_txclk_o(txc[p]), .mii_rxclk_o(rxc[p]),
      .mii_rx_o(rx[p]), .mii_crs_o(crs[p]), .mii_col_o(col[p]), .mdc_i(mdc[p]), .mdio_i(mdw[p]),
      .mdio_o(mdo[p]), .mdio_oe_n_o(oen[p]), .management_disable_strap_i(p == 1),
      .phy_address_strap_high_i(4'h5), .speed_pin_i(p == 1), .duplex_pin_i(1'h0), .line_rx_clk_i(lclk),
      .line_rx_i(lrx), .line_rx_ready_o(rdy[p]), .line_tx_o(ltx[p]), .phy_address_o(pa[p]), .cfg_o(cfg[p])
    );
    dpm_sta_model dpm_sta_model_i
    (.phy_data_i(mdo[p]), .phy_oe_n_i(oen[p]), .mdc_o(mdc[p]), .mdio_o(mdw[p]));
  end
////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask : step
  task automatic mg(input logic port, input logic [1:0] op, input logic [4:0] adr, input logic [15:0] d);
    logic [31:0] f;
    f = {2'h1, op, adr, CTRL_REG_ADDR, 2'h2, d};
    if (port)
      g[1].dpm_sta_model_i.xfer(f, rd);
    else
      g[0].dpm_sta_model_i.xfer(f, rd);
    step(10);
  endtask : mg
  // Counts clock rises over a fixed window that is a whole number of periods at either rate.
  task automatic rises(input logic [15:0] exp);
    logic [15:0] n;
    logic        last;
    logic        same;
    n = 16'h0000;
    last = txc[0];
    same = 1'h1;
    repeat (64)
    begin
      @(negedge clk);
      if (txc[0] && !last)
        n++;
      same &= (rxc[0] === txc[0]);
      last = txc[0];
    end
    step(1);
    chk(n, exp);
    chk(same, 16'h0001);
  endtask : rises
////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    lclk = 1'h0;
    forever #200 lclk = ~lclk;
  end
  initial
  begin
    #1_000_000;
    error_cnt++;
    complete_run();
  end
  initial
  begin
    reset_n = 1'h0;
    tx = 6'h3F;
    lrx = 6'h00;
    error_cnt = 0;
    check_count = 0;
    step(4);
    chk(ltx[0], 16'h0000);
    chk(oen[0], 16'h0001);
    reset_n = 1'h1;
    step(10);
    chk(pa[0], 16'h000A);
    chk(pa[1], 16'h000B);
    chk(cfg[0], 16'h0000);
    rises(16'h0008);
    for (int r = 0; r < 6; r++)
    begin
      if (r == 4)
      begin
        mg(1'h0, OP_WRITE, 5'h0C, 16'h2100);
        chk(cfg[0], 16'h0000);
        mg(1'h0, OP_WRITE, 5'h0A, 16'h2100);
        mg(1'h1, OP_WRITE, 5'h0B, 16'h2100);
        chk(cfg[0], 16'h0003);
        chk(cfg[1], 16'h0002);
        rises(16'h0020);
      end
      tx = ROWS[r].tx;
      @(negedge lclk) lrx = ROWS[r].lrx;
      step(48);
      chk(ltx[0], ROWS[r].ltx);
      if (ROWS[r].chk)
        chk(rx[0], ROWS[r].rx);
      chk(crs[0], ROWS[r].crs);
      chk(col[0], ROWS[r].col);
      chk(rdy[0], 16'h0001);
    end
    mg(1'h0, OP_READ, 5'h0A, 16'h0000);
    chk(rd, 16'h2100);
    mg(1'h1, OP_READ, 5'h0B, 16'h0000);
    chk(rd, 16'hFFFF);
    mg(1'h0, OP_WRITE, 5'h0A, 16'hA100);
    chk(cfg[0], 16'h0000);
    mg(1'h0, OP_READ, 5'h0A, 16'h0000);
    chk(rd, 16'h0000);
    rises(16'h0008);
    complete_run();
  end
endmodule : dpm_port_bench
`default_nettype wire
